//--- hdl/insn_dec_pkg.sv
// constants, field layouts and carrier types for the 14-bit instruction decoder
`default_nettype none
package insn_dec_pkg;

   // =============================================
   // word and field layout
   localparam int WORD_W = 14;
   localparam int CLS_HI = 13;
   localparam int CLS_LO = 12;
   localparam int SEL_HI = 11;
   localparam int SEL_LO = 8;
   localparam int DEST_BIT = 7;
   localparam int BITN_HI = 9;
   localparam int BITN_LO = 7;
   localparam int FADDR_HI = 6;
   localparam int LIT8_HI = 7;
   localparam int LIT11_HI = 10;
   localparam int JUMP_BIT = 11;
   localparam int BITOP_HI = 11;
   localparam int BITOP_LO = 10;

   // =============================================
   // class and selector codes
   localparam logic [1:0] CLS_BYTE = 2'h0;
   localparam logic [1:0] CLS_BIT = 2'h1;
   localparam logic [1:0] CLS_CTRL = 2'h2;
   localparam logic [1:0] CLS_LIT = 2'h3;
   localparam logic [3:0] SEL_MISC = 4'h0;
   localparam logic [3:0] SEL_CLR = 4'h1;
   localparam logic [3:0] SEL_SUB = 4'h2;
   localparam logic [3:0] SEL_DEC = 4'h3;
   localparam logic [3:0] SEL_IOR = 4'h4;
   localparam logic [3:0] SEL_AND = 4'h5;
   localparam logic [3:0] SEL_XOR = 4'h6;
   localparam logic [3:0] SEL_ADD = 4'h7;
   localparam logic [3:0] SEL_MOV = 4'h8;
   localparam logic [3:0] SEL_COM = 4'h9;
   localparam logic [3:0] SEL_INC = 4'hA;
   localparam logic [3:0] SEL_DECSZ = 4'hB;
   localparam logic [3:0] SEL_RR = 4'hC;
   localparam logic [3:0] SEL_RL = 4'hD;
   localparam logic [3:0] SEL_SWAP = 4'hE;
   localparam logic [3:0] SEL_INCSZ = 4'hF;
   localparam logic [3:0] LSEL_IOR = 4'h8;
   localparam logic [3:0] LSEL_AND = 4'h9;
   localparam logic [3:0] LSEL_XOR = 4'hA;
   localparam logic [1:0] BOP_CLR = 2'h0;
   localparam logic [1:0] BOP_SET = 2'h1;
   localparam logic [1:0] BOP_TSC = 2'h2;
   localparam logic [1:0] BOP_TSS = 2'h3;

   // =============================================
   // fixed control words and reset values
   localparam logic [13:0] WORD_NOP = 14'h0000;
   localparam logic [13:0] WORD_SLEEP = 14'h0063;
   localparam logic [13:0] WORD_WDCLR = 14'h0064;
   localparam logic [13:0] WORD_IRET = 14'h0009;
   localparam logic [13:0] WORD_RET = 14'h0008;
   localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
   localparam logic [7:0] WREG_RST = 8'h00;
   localparam int OSC_PER_CYCLE = 4;

   // =============================================
   // types
   typedef enum logic [5:0] {
      OPK_NOP, OPK_STORE_WREG_FILE, OPK_CLEAR_WREG, OPK_CLEAR_FILE,
      OPK_SUBTRACT_WREG_FILE, OPK_DECREMENT_FILE, OPK_OR_WREG_FILE, OPK_AND_WREG_FILE,
      OPK_XOR_WREG_FILE, OPK_ADD_WREG_FILE, OPK_MOVE_FILE, OPK_COMPLEMENT_FILE,
      OPK_INCREMENT_FILE, OPK_DECREMENT_SKIP_ZERO, OPK_ROTATE_RIGHT_CARRY,
      OPK_ROTATE_LEFT_CARRY, OPK_SWAP_NIBBLES, OPK_INCREMENT_SKIP_ZERO,
      OPK_BIT_CLEAR, OPK_BIT_SET, OPK_BIT_TEST_SKIP_CLEAR, OPK_BIT_TEST_SKIP_SET,
      OPK_CALL, OPK_JUMP, OPK_LOAD_LITERAL, OPK_RETURN_WITH_LITERAL,
      OPK_SUBTRACT_FROM_LITERAL, OPK_ADD_LITERAL, OPK_OR_LITERAL, OPK_AND_LITERAL,
      OPK_XOR_LITERAL, OPK_RETURN, OPK_INTERRUPT_RETURN, OPK_SLEEP, OPK_WATCHDOG_CLEAR
   } op_kind_t;

   typedef struct packed {
      op_kind_t kind;
      logic dest;
      logic [6:0] faddr;
      logic [2:0] bitn;
      logic [7:0] lit8;
      logic [10:0] lit11;
   } dec_t;

   typedef struct packed {
      logic timeout_flag;
      logic powerdown_flag;
      logic zero_flag;
      logic digit_carry_flag;
      logic carry_flag;
   } flags_t;

   localparam flags_t FLAGS_RST = 5'h18;

   typedef enum logic [3:0] {
      PH_Q1 = 4'b0001,
      PH_Q2 = 4'b0010,
      PH_Q3 = 4'b0100,
      PH_Q4 = 4'b1000
   } phase_t;

endpackage
`default_nettype wire

//--- hdl/quad_phase_gen.sv
// four-phase sequencer that splits each instruction cycle into oscillator periods
`default_nettype none
module quad_phase_gen
   import insn_dec_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   output phase_t phase_o,
   output logic cycle_end_o
);

   // =============================================
   // phase ring
   phase_t phase_q;

   // one instruction cycle is four clocks; the ring restarts at q1
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         phase_q <= PH_Q1;
      end else begin
         unique case (phase_q)
            PH_Q1: phase_q <= PH_Q2;
            PH_Q2: phase_q <= PH_Q3;
            PH_Q3: phase_q <= PH_Q4;
            PH_Q4: phase_q <= PH_Q1;
            default: phase_q <= PH_Q1;
         endcase
      end
   end

   assign phase_o = phase_q;
   assign cycle_end_o = (phase_q == PH_Q4);

endmodule
`default_nettype wire

//--- hdl/insn_field_decode.sv
// splits a 14-bit instruction word into operation kind and operand fields
`default_nettype none
module insn_field_decode
   import insn_dec_pkg::*;
(
   input wire logic [13:0] word_i,
   output dec_t dec_o
);

   // =============================================
   // field extraction and class decode
   logic [1:0] cls;
   logic [3:0] sel;

   assign cls = word_i[CLS_HI:CLS_LO];
   assign sel = word_i[SEL_HI:SEL_LO];

   // don't-care bits are simply never looked at
   always_comb begin
      dec_o.dest = word_i[DEST_BIT];
      dec_o.faddr = word_i[FADDR_HI:0];
      dec_o.bitn = word_i[BITN_HI:BITN_LO];
      dec_o.lit8 = word_i[LIT8_HI:0];
      dec_o.lit11 = word_i[LIT11_HI:0];
      dec_o.kind = OPK_NOP;
      unique case (cls)
         CLS_BYTE: begin
            unique case (sel)
               SEL_MISC: begin
                  if (word_i[DEST_BIT]) begin
                     dec_o.kind = OPK_STORE_WREG_FILE;
                  end else if (word_i == WORD_SLEEP) begin
                     dec_o.kind = OPK_SLEEP;
                  end else if (word_i == WORD_WDCLR) begin
                     dec_o.kind = OPK_WATCHDOG_CLEAR;
                  end else if (word_i == WORD_IRET) begin
                     dec_o.kind = OPK_INTERRUPT_RETURN;
                  end else if (word_i == WORD_RET) begin
                     dec_o.kind = OPK_RETURN;
                  end else begin
                     dec_o.kind = OPK_NOP;
                  end
               end
               SEL_CLR: dec_o.kind = word_i[DEST_BIT] ? OPK_CLEAR_FILE : OPK_CLEAR_WREG;
               SEL_SUB: dec_o.kind = OPK_SUBTRACT_WREG_FILE;
               SEL_DEC: dec_o.kind = OPK_DECREMENT_FILE;
               SEL_IOR: dec_o.kind = OPK_OR_WREG_FILE;
               SEL_AND: dec_o.kind = OPK_AND_WREG_FILE;
               SEL_XOR: dec_o.kind = OPK_XOR_WREG_FILE;
               SEL_ADD: dec_o.kind = OPK_ADD_WREG_FILE;
               SEL_MOV: dec_o.kind = OPK_MOVE_FILE;
               SEL_COM: dec_o.kind = OPK_COMPLEMENT_FILE;
               SEL_INC: dec_o.kind = OPK_INCREMENT_FILE;
               SEL_DECSZ: dec_o.kind = OPK_DECREMENT_SKIP_ZERO;
               SEL_RR: dec_o.kind = OPK_ROTATE_RIGHT_CARRY;
               SEL_RL: dec_o.kind = OPK_ROTATE_LEFT_CARRY;
               SEL_SWAP: dec_o.kind = OPK_SWAP_NIBBLES;
               SEL_INCSZ: dec_o.kind = OPK_INCREMENT_SKIP_ZERO;
            endcase
         end
         CLS_BIT: begin
            unique case (word_i[BITOP_HI:BITOP_LO])
               BOP_CLR: dec_o.kind = OPK_BIT_CLEAR;
               BOP_SET: dec_o.kind = OPK_BIT_SET;
               BOP_TSC: dec_o.kind = OPK_BIT_TEST_SKIP_CLEAR;
               BOP_TSS: dec_o.kind = OPK_BIT_TEST_SKIP_SET;
            endcase
         end
         CLS_CTRL: dec_o.kind = word_i[JUMP_BIT] ? OPK_JUMP : OPK_CALL;
         CLS_LIT: begin
            if (sel[3:2] == 2'h0) begin
               dec_o.kind = OPK_LOAD_LITERAL;
            end else if (sel[3:2] == 2'h1) begin
               dec_o.kind = OPK_RETURN_WITH_LITERAL;
            end else if (sel[3:1] == 3'h7) begin
               dec_o.kind = OPK_ADD_LITERAL;
            end else if (sel[3:1] == 3'h6) begin
               dec_o.kind = OPK_SUBTRACT_FROM_LITERAL;
            end else if (sel == LSEL_IOR) begin
               dec_o.kind = OPK_OR_LITERAL;
            end else if (sel == LSEL_AND) begin
               dec_o.kind = OPK_AND_LITERAL;
            end else if (sel == LSEL_XOR) begin
               dec_o.kind = OPK_XOR_LITERAL;
            end else begin
               dec_o.kind = OPK_NOP;
            end
         end
      endcase
   end

endmodule
`default_nettype wire

//--- hdl/mcu_instruction_decoder_14bit.sv
// instruction decode, execute timing and status flags of the 8-bit core
// Function
// - each instruction is one 14-bit word
// - destination bit zero writes W, one writes file
// - file address is the low seven bits
// - three-bit field picks the bit operated on
// - literals are eight or eleven bits wide
// - skips and branches take two cycles, second idle
// - one instruction cycle is four oscillator periods
// - byte logic ops by selector, zero flag only
// - rotates go through carry, change carry only
// - skip-on-zero ops write result, no flags
// - bit ops clear, set, test-skip clear, test-skip set
// - literal logic ops combine W, update zero
// - literal add and subtract update C, DC, Z
// - load literal one cycle, return with literal two
// - call or jump by bit eleven, two cycles
// - fixed control words decoded exactly
// - write to timer zero clears prescaler if timer owns it
// - don't-care bits are ignored
// - standby clears powerdown, sets timeout flag
// - watchdog clear resets prescaler if watchdog owns it
`default_nettype none
module mcu_instruction_decoder_14bit
   import insn_dec_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [13:0] instr_word_i,
   input wire logic [7:0] file_rdata_i,
   input wire logic presc_to_wdt_i,
   output phase_t phase_o,
   output logic [6:0] file_addr_o,
   output logic [7:0] file_wdata_o,
   output logic file_we_o,
   output logic [7:0] wreg_o,
   output flags_t status_o,
   output logic filler_cycle_o,
   output logic pc_load_o,
   output logic [10:0] pc_target_o,
   output logic stack_push_o,
   output logic stack_pop_o,
   output logic intr_return_o,
   output logic presc_clr_o,
   output logic wdt_clr_o,
   output logic sleep_o
);

   // =============================================
   // phase sequencer and decoder
   logic cyc_end;
   logic [13:0] insn_q;
   dec_t dec;

   quad_phase_gen u_phase (
      .ref_clk_i(ref_clk_i),
      .rst_b_i(rst_b_i),
      .phase_o(phase_o),
      .cycle_end_o(cyc_end)
   );

   insn_field_decode u_dec (
      .word_i(insn_q),
      .dec_o(dec)
   );

   // =============================================
   // arithmetic helpers
   // returns {carry, digit carry, sum}
   function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
      logic [4:0] lo;
      logic [8:0] full;
      lo = 5'({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin});
      full = 9'({1'b0, a} + {1'b0, b} + {8'h00, cin});
      return {full[8], lo[4], full[7:0]};
   endfunction

   function automatic logic is_zero(input logic [7:0] v);
      return (v == 8'h00);
   endfunction

   // =============================================
   // execute: combinational result of the current word
   logic [7:0] w_q;
   flags_t stat_q;
   logic [7:0] res;
   logic [9:0] sum;
   logic wr_f;
   logic wr_w;
   flags_t nf;
   logic take_two;
   logic pcl;
   logic push;
   logic pop;
   logic iret;
   logic wclr;
   logic slp;
   logic pclr;

   always_comb begin
      res = 8'h00;
      sum = 10'h000;
      wr_f = 1'b0;
      wr_w = 1'b0;
      nf = stat_q;
      take_two = 1'b0;
      pcl = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      iret = 1'b0;
      wclr = 1'b0;
      slp = 1'b0;
      unique case (dec.kind)
         OPK_NOP: res = 8'h00;
         OPK_STORE_WREG_FILE: begin
            res = w_q;
            wr_f = 1'b1;
         end
         OPK_CLEAR_WREG, OPK_CLEAR_FILE: begin
            res = 8'h00;
            wr_f = (dec.kind == OPK_CLEAR_FILE);
            wr_w = (dec.kind == OPK_CLEAR_WREG);
            nf.zero_flag = 1'b1;
         end
         OPK_ADD_WREG_FILE, OPK_SUBTRACT_WREG_FILE, OPK_ADD_LITERAL,
         OPK_SUBTRACT_FROM_LITERAL: begin
            // subtraction is a + ~w + 1, so carry reads as no-borrow
            if (dec.kind == OPK_ADD_WREG_FILE) sum = add8(file_rdata_i, w_q, 1'b0);
            else if (dec.kind == OPK_SUBTRACT_WREG_FILE) sum = add8(file_rdata_i, ~w_q, 1'b1);
            else if (dec.kind == OPK_ADD_LITERAL) sum = add8(dec.lit8, w_q, 1'b0);
            else sum = add8(dec.lit8, ~w_q, 1'b1);
            res = sum[7:0];
            nf.carry_flag = sum[9];
            nf.digit_carry_flag = sum[8];
            nf.zero_flag = is_zero(sum[7:0]);
            wr_f = dec.dest && !dec.kind[5];
            wr_w = !(dec.dest && !dec.kind[5]);
            if (dec.kind == OPK_ADD_LITERAL || dec.kind == OPK_SUBTRACT_FROM_LITERAL) begin
               wr_f = 1'b0;
               wr_w = 1'b1;
            end
         end
         OPK_OR_WREG_FILE, OPK_AND_WREG_FILE, OPK_XOR_WREG_FILE, OPK_COMPLEMENT_FILE,
         OPK_MOVE_FILE, OPK_DECREMENT_FILE, OPK_INCREMENT_FILE: begin
            if (dec.kind == OPK_OR_WREG_FILE) res = file_rdata_i | w_q;
            else if (dec.kind == OPK_AND_WREG_FILE) res = file_rdata_i & w_q;
            else if (dec.kind == OPK_XOR_WREG_FILE) res = file_rdata_i ^ w_q;
            else if (dec.kind == OPK_COMPLEMENT_FILE) res = ~file_rdata_i;
            else if (dec.kind == OPK_MOVE_FILE) res = file_rdata_i;
            else if (dec.kind == OPK_DECREMENT_FILE) res = 8'(file_rdata_i - 8'h01);
            else res = 8'(file_rdata_i + 8'h01);
            nf.zero_flag = is_zero(res);
            wr_f = dec.dest;
            wr_w = !dec.dest;
         end
         OPK_DECREMENT_SKIP_ZERO, OPK_INCREMENT_SKIP_ZERO: begin
            if (dec.kind == OPK_DECREMENT_SKIP_ZERO) res = 8'(file_rdata_i - 8'h01);
            else res = 8'(file_rdata_i + 8'h01);
            wr_f = dec.dest;
            wr_w = !dec.dest;
            take_two = is_zero(res);
         end
         OPK_ROTATE_LEFT_CARRY, OPK_ROTATE_RIGHT_CARRY: begin
            if (dec.kind == OPK_ROTATE_LEFT_CARRY) begin
               res = {file_rdata_i[6:0], stat_q.carry_flag};
               nf.carry_flag = file_rdata_i[7];
            end else begin
               res = {stat_q.carry_flag, file_rdata_i[7:1]};
               nf.carry_flag = file_rdata_i[0];
            end
            wr_f = dec.dest;
            wr_w = !dec.dest;
         end
         OPK_SWAP_NIBBLES: begin
            res = {file_rdata_i[3:0], file_rdata_i[7:4]};
            wr_f = dec.dest;
            wr_w = !dec.dest;
         end
         OPK_BIT_CLEAR, OPK_BIT_SET: begin
            res = file_rdata_i;
            res[dec.bitn] = (dec.kind == OPK_BIT_SET);
            wr_f = 1'b1;
         end
         OPK_BIT_TEST_SKIP_CLEAR: take_two = !file_rdata_i[dec.bitn];
         OPK_BIT_TEST_SKIP_SET: take_two = file_rdata_i[dec.bitn];
         OPK_CALL, OPK_JUMP: begin
            pcl = 1'b1;
            push = (dec.kind == OPK_CALL);
            take_two = 1'b1;
         end
         OPK_LOAD_LITERAL, OPK_RETURN_WITH_LITERAL: begin
            res = dec.lit8;
            wr_w = 1'b1;
            pop = (dec.kind == OPK_RETURN_WITH_LITERAL);
            take_two = pop;
         end
         OPK_OR_LITERAL, OPK_AND_LITERAL, OPK_XOR_LITERAL: begin
            if (dec.kind == OPK_OR_LITERAL) res = dec.lit8 | w_q;
            else if (dec.kind == OPK_AND_LITERAL) res = dec.lit8 & w_q;
            else res = dec.lit8 ^ w_q;
            wr_w = 1'b1;
            nf.zero_flag = is_zero(res);
         end
         OPK_RETURN, OPK_INTERRUPT_RETURN: begin
            pop = 1'b1;
            iret = (dec.kind == OPK_INTERRUPT_RETURN);
            take_two = 1'b1;
         end
         OPK_SLEEP: begin
            slp = 1'b1;
            wclr = 1'b1;
            nf.powerdown_flag = 1'b0;
            nf.timeout_flag = 1'b1;
         end
         OPK_WATCHDOG_CLEAR: begin
            wclr = 1'b1;
            nf.powerdown_flag = 1'b1;
            nf.timeout_flag = 1'b1;
         end
      endcase
   end

   // timer write clears the prescaler when the timer owns it; watchdog clears clear it when the watchdog owns it
   assign pclr = (wr_f && dec.faddr == TIMER_ZERO_ADDR && !presc_to_wdt_i)
                 || (wclr && presc_to_wdt_i);

   // =============================================
   // instruction register and filler cycle
   logic filler_q;
   logic [6:0] addr_q;

   // the word fetched alongside a taken skip or branch is replaced by a no-op
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         insn_q <= WORD_NOP;
         filler_q <= 1'b0;
         addr_q <= 7'h00;
      end else if (cyc_end) begin
         insn_q <= take_two ? WORD_NOP : instr_word_i;
         filler_q <= take_two;
         addr_q <= take_two ? WORD_NOP[FADDR_HI:0] : instr_word_i[FADDR_HI:0];
      end
   end

   // =============================================
   // working register and status flags
   // commit at the q4 edge so the file read has had four clocks to settle
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         w_q <= WREG_RST;
      end else if (cyc_end && wr_w) begin
         w_q <= res;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         stat_q <= FLAGS_RST;
      end else if (cyc_end) begin
         stat_q <= nf;
      end
   end

   // =============================================
   // one-clock strobes towards datapath, stack and timers
   logic we_q;
   logic [7:0] wdata_q;
   logic pcl_q;
   logic [10:0] tgt_q;
   logic push_q;
   logic pop_q;
   logic iret_q;
   logic pclr_q;
   logic wclr_q;
   logic slp_q;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         we_q <= 1'b0;
         wdata_q <= 8'h00;
      end else begin
         we_q <= cyc_end && wr_f;
         if (cyc_end && wr_f) wdata_q <= res;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         pcl_q <= 1'b0;
         tgt_q <= 11'h000;
         push_q <= 1'b0;
         pop_q <= 1'b0;
         iret_q <= 1'b0;
      end else begin
         pcl_q <= cyc_end && pcl;
         if (cyc_end && pcl) tgt_q <= dec.lit11;
         push_q <= cyc_end && push;
         pop_q <= cyc_end && pop;
         iret_q <= cyc_end && iret;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         pclr_q <= 1'b0;
         wclr_q <= 1'b0;
         slp_q <= 1'b0;
      end else begin
         pclr_q <= cyc_end && pclr;
         wclr_q <= cyc_end && wclr;
         slp_q <= cyc_end && slp;
      end
   end

   assign file_addr_o = addr_q;
   assign file_wdata_o = wdata_q;
   assign file_we_o = we_q;
   assign wreg_o = w_q;
   assign status_o = stat_q;
   assign filler_cycle_o = filler_q;
   assign pc_load_o = pcl_q;
   assign pc_target_o = tgt_q;
   assign stack_push_o = push_q;
   assign stack_pop_o = pop_q;
   assign intr_return_o = iret_q;
   assign presc_clr_o = pclr_q;
   assign wdt_clr_o = wclr_q;
   assign sleep_o = slp_q;

   // =============================================
   // checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);

   cycle_period_a: assert property (cyc_end |=> !cyc_end [*3] ##1 cyc_end)
      else $error("instruction cycle is not four clocks");
   wreg_dest_a: assert property ((cyc_end && dec.kind == OPK_AND_WREG_FILE && !dec.dest)
      |=> !file_we_o && wreg_o == $past(res))
      else $error("destination zero did not go to W");
   file_addr_a: assert property ((cyc_end && !take_two)
      |=> file_addr_o == $past(instr_word_i[6:0]))
      else $error("file address not low seven bits");
   filler_run_a: assert property ((cyc_end && take_two) |=> filler_cycle_o [*4])
      else $error("filler cycle missing after taken skip");
   sleep_flags_a: assert property ((cyc_end && dec.kind == OPK_SLEEP)
      |=> sleep_o && !status_o.powerdown_flag && status_o.timeout_flag)
      else $error("standby flags wrong");
   logic_flags_a: assert property ((cyc_end && dec.kind == OPK_XOR_WREG_FILE)
      |=> status_o.carry_flag == $past(stat_q.carry_flag)
          && status_o.digit_carry_flag == $past(stat_q.digit_carry_flag))
      else $error("logic op touched carry flags");
   rotate_carry_a: assert property ((cyc_end && dec.kind == OPK_ROTATE_LEFT_CARRY)
      |=> status_o.carry_flag == $past(file_rdata_i[7])
          && status_o.zero_flag == $past(stat_q.zero_flag))
      else $error("rotate left carry wrong");
   skip_zero_a: assert property ((cyc_end && dec.kind == OPK_DECREMENT_SKIP_ZERO
      && file_rdata_i == 8'h01) |=> filler_cycle_o)
      else $error("decrement to zero did not skip");
   jump_target_a: assert property ((cyc_end && dec.kind == OPK_JUMP)
      |=> pc_load_o && !stack_push_o && pc_target_o == $past(insn_q[10:0]))
      else $error("jump target not loaded");
   timer_presc_a: assert property ((cyc_end && dec.kind == OPK_CLEAR_FILE
      && dec.faddr == TIMER_ZERO_ADDR && !presc_to_wdt_i) |=> presc_clr_o)
      else $error("timer write did not clear prescaler");
   wdt_presc_a: assert property ((cyc_end && dec.kind == OPK_WATCHDOG_CLEAR)
      |=> wdt_clr_o && presc_clr_o == $past(presc_to_wdt_i))
      else $error("watchdog clear prescaler handling wrong");

endmodule
`default_nettype wire

//--- verif/prog_mem.sv
// program memory model feeding the decoder
`default_nettype none
module prog_mem
   import insn_dec_pkg::*;
(
   input wire logic ref_clk_i,
   input wire phase_t phase_i,
   input wire logic [13:0] feed_i,
   output logic [13:0] word_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ====
   // one whole word per cycle, changed only ahead of the taking edge
   initial word_o = WORD_NOP;
   always @(negedge ref_clk_i) begin
      if (phase_i == PH_Q4) begin
         word_o <= feed_i;
      end
   end
endmodule
`default_nettype wire

//--- verif/tb.sv
// self-checking bench for the instruction decoder
`default_nettype none
module tb
   import insn_dec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
$display("BAD %s exp %h got %h", n, e, g); end end
   logic ref_clk_i = 0, rst_b_i = 0, presc_to_wdt_i = 0;
   logic [13:0] feed = WORD_NOP, instr_word_i;
   logic [7:0] file_rdata_i = 8'h00, file_wdata_o, wreg_o;
   int fails = 0, total_checks = 0;
   phase_t phase_o;
   flags_t status_o;
   logic [6:0] file_addr_o;
   logic [10:0] pc_target_o;
   logic file_we_o, filler_cycle_o, pc_load_o, stack_push_o, stack_pop_o;
   logic intr_return_o, presc_clr_o, wdt_clr_o, sleep_o;
   mcu_instruction_decoder_14bit dut (.*);
   prog_mem mem (.ref_clk_i, .phase_i(phase_o), .feed_i(feed), .word_o(instr_word_i));
   // ====
   // clock
   initial begin
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   // one word in, then a no-op; ends where the result stands
   task automatic run(input logic [13:0] w, input logic [7:0] rd);
      feed = w;
      file_rdata_i = rd;
      do @(negedge ref_clk_i); while (phase_o !== PH_Q4);
      @(negedge ref_clk_i);
      `CHK("addr", w[6:0], file_addr_o)
      `CHK("phase", PH_Q1, phase_o)
      feed = WORD_NOP;
      repeat (OSC_PER_CYCLE) @(negedge ref_clk_i);
   endtask
   task automatic t_lit;
      run(14'h3055, 8'h00);
      `CHK("wreg", 8'h55, wreg_o)
      `CHK("flags", 5'h18, status_o)
      run(14'h3EAB, 8'h00);
      `CHK("wreg", 8'h00, wreg_o)
      `CHK("flags", 5'h1F, status_o)
      $display("lit done");
   endtask
   task automatic t_file;
      run(14'h0690, 8'hFF);
      `CHK("we", 1'b1, file_we_o)
      `CHK("wdata", 8'hFF, file_wdata_o)
      `CHK("flags", 5'h1B, status_o)
      run(14'h0B90, 8'h01);
      `CHK("skip", 1'b1, filler_cycle_o)
      `CHK("wdata", 8'h00, file_wdata_o)
      `CHK("flags", 5'h1B, status_o)
      run(14'h0081, 8'h00);
      `CHK("pclr", 1'b1, presc_clr_o)
      $display("file done");
   endtask
   task automatic t_branch;
      run(14'h2805, 8'h00);
      `CHK("load", 1'b1, pc_load_o)
      `CHK("tgt", 11'h005, pc_target_o)
      `CHK("fill", 1'b1, filler_cycle_o)
      run(14'h2123, 8'h00);
      `CHK("push", 1'b1, stack_push_o)
      `CHK("tgt", 11'h123, pc_target_o)
      $display("branch done");
   endtask
   task automatic t_ctrl;
      run(14'h0063, 8'h00);
      `CHK("sleep", 1'b1, sleep_o)
      `CHK("flags", 5'h13, status_o)
      presc_to_wdt_i = 1;
      run(14'h0064, 8'h00);
      `CHK("wclr", 1'b1, wdt_clr_o)
      `CHK("pclr", 1'b1, presc_clr_o)
      `CHK("flags", 5'h1B, status_o)
      run(14'h0009, 8'h00);
      `CHK("iret", 1'b1, intr_return_o)
      `CHK("pop", 1'b1, stack_pop_o)
      $display("ctrl done");
   endtask
   // file-side ops; some words carry don't-care bits set on purpose
   task automatic t_fileops;
      run(14'h3355, 8'h00);
      `CHK("wreg", 8'h55, wreg_o)
      run(14'h0510, 8'h0F);
      `CHK("wreg", 8'h05, wreg_o)
      `CHK("we", 1'b0, file_we_o)
      run(14'h0D90, 8'h01);
      `CHK("wdata", 8'h03, file_wdata_o)
      `CHK("flags", 5'h1A, status_o)
      run(14'h0C90, 8'h01);
      `CHK("wdata", 8'h00, file_wdata_o)
      `CHK("flags", 5'h1B, status_o)
      presc_to_wdt_i = 0;
      run(14'h0181, 8'h00);
      `CHK("pclr", 1'b1, presc_clr_o)
      `CHK("flags", 5'h1F, status_o)
      run(14'h017F, 8'h00);
      `CHK("wreg", 8'h00, wreg_o)
      `CHK("we", 1'b0, file_we_o)
      $display("fileops done");
   endtask
   // bit ops, tests and the literal forms
   task automatic t_bitlit;
      run(14'h1590, 8'h00);
      `CHK("wdata", 8'h08, file_wdata_o)
      run(14'h1990, 8'h08);
      `CHK("skip", 1'b0, filler_cycle_o)
      run(14'h1D90, 8'h08);
      `CHK("skip", 1'b1, filler_cycle_o)
      run(14'h38F0, 8'h00);
      `CHK("wreg", 8'hF0, wreg_o)
      `CHK("flags", 5'h1B, status_o)
      run(14'h3AF0, 8'h00);
      `CHK("wreg", 8'h00, wreg_o)
      `CHK("flags", 5'h1F, status_o)
      run(14'h3C03, 8'h00);
      `CHK("wreg", 8'h03, wreg_o)
      run(14'h3C01, 8'h00);
      `CHK("wreg", 8'hFE, wreg_o)
      `CHK("flags", 5'h18, status_o)
      run(14'h3477, 8'h00);
      `CHK("wreg", 8'h77, wreg_o)
      `CHK("pop", 1'b1, stack_pop_o)
      run(14'h0008, 8'h00);
      `CHK("pop", 1'b1, stack_pop_o)
      `CHK("iret", 1'b0, intr_return_o)
      `CHK("fill", 1'b1, filler_cycle_o)
      $display("bitlit done");
   endtask
   // ====
   // verdict
   task automatic close_out;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(negedge ref_clk_i);
      rst_b_i = 1;
      t_lit;
      t_file;
      t_branch;
      t_ctrl;
      t_fileops;
      t_bitlit;
      close_out;
   end
   // about 204 clock cycles expected; wide margin for slow filler paths
   initial begin
      repeat (2000) @(negedge ref_clk_i);
      fails++;
      close_out;
   end
endmodule
`default_nettype wire
